// ==== core/dpmc_top.sv ====
/*
 * Per-port counter control and the two mailbox flags of a dual-port RAM.
 * Assumes both host controllers run on REF_CLK; the global reset pin is
 * asynchronous and is synchronised here before use.
 */
`timescale 1ns/1ps
module dpmc_top #(
    parameter int AW = dpmc_pkg::ADDR_W,
    parameter int BW = dpmc_pkg::BYTE_LANES
) (
    input  wire logic          REF_CLK,
    input  wire logic          SRST,
    input  wire logic          CE,
    input  wire logic          GLOBAL_RESET_INPUT_N,
    input  wire logic [1:0]    LOW_ACTIVE_SELECT_N,
    input  wire logic [1:0]    HIGH_ACTIVE_SELECT,
    input  wire logic [1:0]    READ_NOT_WRITE,
    input  wire logic [2*BW-1:0] BYTE_LANE_ENABLE_N,
    input  wire logic [2*AW-1:0] ADDR_IN,
    input  wire logic [1:0]    COUNTER_OR_MASK_SELECT,
    input  wire logic [1:0]    COUNTER_CLEAR_INPUT_N,
    input  wire logic [1:0]    LOAD_STROBE_N,
    input  wire logic [1:0]    COUNT_ADVANCE_ENABLE_N,
    input  wire logic [1:0]    WRAP_CHOICE_INPUT,
    input  wire logic [1:0]    BLOCK_REPLAY_INPUT,
    input  wire logic [1:0]    FLOW_THROUGH_SELECT,
    output logic      [2*AW-1:0] ADDR_OUT,
    output logic      [1:0]    ADDR_OE,
    output logic      [2*AW-1:0] COUNTER_ADDR,
    output logic      [1:0]    COUNTER_WRAP_FLAG_N,
    output logic      [1:0]    FLOW_THROUGH_MODE,
    output logic      [1:0]    DATA_OE,
    output logic               LEFT_MAILBOX_FLAG_N,
    output logic               RIGHT_MAILBOX_FLAG_N
);
    // --------------------------------------------------------------
    // Global reset synchroniser
    // --------------------------------------------------------------
    logic [dpmc_pkg::SYNC_STAGES-1:0] grst_sync_r, grst_sync_nxt;
    logic                             grst_r, grst_nxt;
    logic                             rst_all;

    always_comb begin
        grst_sync_nxt = {grst_sync_r[dpmc_pkg::SYNC_STAGES-2:0], GLOBAL_RESET_INPUT_N};
        grst_nxt      = grst_r;
        // A change counts once the last two stages agree.
        if (grst_sync_r[2] == grst_sync_r[1])
            grst_nxt = ~grst_sync_r[2];
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            grst_sync_r <= '0;
            grst_r      <= 1'b1;
        end else if (CE) begin
            grst_sync_r <= grst_sync_nxt;
            grst_r      <= grst_nxt;
        end
    end

    // RL4 both ports reset
    assign rst_all = SRST | grst_r;

    // --------------------------------------------------------------
    // Per-port counters and chip select
    // --------------------------------------------------------------
    logic [1:0] sel_act;
    logic [1:0] sel_d_r, sel_d_nxt, sel_dd_r, sel_dd_nxt;

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            // RL14 combined select
            assign sel_act[p] = ~LOW_ACTIVE_SELECT_N[p] & HIGH_ACTIVE_SELECT[p];
            // RL23 no chip select
            dpmc_port_ctr #(.AW(AW)) u_ctr (
                .clk         (REF_CLK),
                .rst         (rst_all),
                .ce          (CE),
                .cnt_sel     (COUNTER_OR_MASK_SELECT[p]),
                .clr_n       (COUNTER_CLEAR_INPUT_N[p]),
                .load_n      (LOAD_STROBE_N[p]),
                .adv_n       (COUNT_ADVANCE_ENABLE_N[p]),
                .wrap_choice (WRAP_CHOICE_INPUT[p]),
                .addr_in     (ADDR_IN[p*AW +: AW]),
                .addr_out    (ADDR_OUT[p*AW +: AW]),
                .addr_oe     (ADDR_OE[p]),
                .counter     (COUNTER_ADDR[p*AW +: AW]),
                .wrap_flag_n (COUNTER_WRAP_FLAG_N[p])
            );
            // RL3 mode select
            assign FLOW_THROUGH_MODE[p] = FLOW_THROUGH_SELECT[p];
            // Read data window: one cycle after the select edge, or two when pipelined.
            // A later write command must not cut the window of an earlier read.
            assign DATA_OE[p] = ~ADDR_OE[p] &
                                (FLOW_THROUGH_SELECT[p] ? sel_d_r[p] : sel_dd_r[p]);
        end
    endgenerate

    always_comb begin
        sel_d_nxt  = sel_act & READ_NOT_WRITE;
        sel_dd_nxt = sel_d_r;
    end

    always_ff @(posedge REF_CLK) begin
        if (rst_all) begin
            sel_d_r  <= 2'b00;
            sel_dd_r <= 2'b00;
        end else if (CE) begin
            sel_d_r  <= sel_d_nxt;
            sel_dd_r <= sel_dd_nxt;
        end
    end

    // --------------------------------------------------------------
    // Mailbox flags
    // --------------------------------------------------------------
    // Port 0 is left, port 1 is right.
    logic [AW-1:0] right_mbox, left_mbox;
    logic [1:0]    lane_ok;
    logic [1:0]    hit_right, hit_left;
    logic          lflag_r, lflag_nxt, rflag_r, rflag_nxt;

    // RL8 mailbox addresses
    assign right_mbox = {AW{1'b1}} - dpmc_pkg::RIGHT_MBOX_OFS;
    assign left_mbox  = {AW{1'b1}} - dpmc_pkg::LEFT_MBOX_OFS;

    always_comb begin
        // RL10 byte lane gate
        lane_ok[0] = ~&BYTE_LANE_ENABLE_N[BW-1:0];
        lane_ok[1] = ~&BYTE_LANE_ENABLE_N[2*BW-1:BW];
        hit_right[0] = sel_act[0] & lane_ok[0] & (ADDR_IN[AW-1:0] == right_mbox);
        hit_right[1] = sel_act[1] & lane_ok[1] & (ADDR_IN[2*AW-1:AW] == right_mbox);
        hit_left[0]  = sel_act[0] & lane_ok[0] & (ADDR_IN[AW-1:0] == left_mbox);
        hit_left[1]  = sel_act[1] & lane_ok[1] & (ADDR_IN[2*AW-1:AW] == left_mbox);
        lflag_nxt = lflag_r;
        rflag_nxt = rflag_r;
        // RL11 owner read clears
        if (hit_right[1] & READ_NOT_WRITE[1])
            rflag_nxt = 1'b1;
        if (hit_left[0] & READ_NOT_WRITE[0])
            lflag_nxt = 1'b1;
        // RL9 RL13 opposite write sets, set wins
        if (hit_right[0] & ~READ_NOT_WRITE[0])
            rflag_nxt = 1'b0;
        if (hit_left[1] & ~READ_NOT_WRITE[1])
            lflag_nxt = 1'b0;
    end

    // RL12 unpipelined flag update
    always_ff @(posedge REF_CLK) begin
        if (rst_all) begin
            lflag_r <= 1'b1;
            rflag_r <= 1'b1;
        end else if (CE) begin
            lflag_r <= lflag_nxt;
            rflag_r <= rflag_nxt;
        end
    end

    assign LEFT_MAILBOX_FLAG_N  = lflag_r;
    assign RIGHT_MAILBOX_FLAG_N = rflag_r;
endmodule

// ==== core/dpmc_pkg.sv ====
/*
 * Constants for the dual-port mailbox and burst counter control block.
 * Assumes a single 200 MHz clock shared by both port controllers.
 */
// Operation
// RL1: Counter flag goes low when an increment leaves all unmasked counter bits at one.
// RL2: After max count, clear unmasked bits if wrap choice low, else reload mirror.
// RL3: Flow-through select high gives flow-through mode, low gives pipelined mode.
// RL4: Global reset acts asynchronously and hits both ports at once; here the pin is first synchronised to REF_CLK.
// RL5: Global reset clears counters to zero and sets masks to all ones.
// RL6: Global reset forces mailbox and counter flags high.
// RL7: System applies global reset after power-up before trusting counter or mailbox.
// RL8: Top address is right mailbox, next lower is left mailbox.
// RL9: Writing the opposite port's mailbox drives the owner's flag low.
// RL10: Mailbox set or clear needs at least one byte lane enabled.
// RL11: Owner's valid read of its own mailbox returns its flag high.
// RL12: Flags update unpipelined, on the writing or reading port's edge.
// RL13: Reading other mailbox never clears; writing own mailbox never sets.
// RL14: Chip select active when low select low and high select high.
// RL15: Counter select high and clear low zero the unmasked counter bits.
// RL16: Counter select, clear high, load low, advance low loads counter from address.
// RL17: Counter select, clear high, load low, advance high reads counter back.
// RL18: Counter select, clear high, load high, advance low increments counter.
// RL19: All four controls high hold the counter unchanged.
// RL20: Mask select low with clear low sets mask to all ones.
// RL21: Mask select, clear high, load low, advance low loads mask from address.
// RL22: Mask select, clear high, load low, advance high reads mask back.
// RL23: Counter and mask controls sample on own clock, ignoring chip selects.
// RL24: Undefined mask combination with load high holds all registers.
package dpmc_pkg;
    localparam int ADDR_W      = 18;
    localparam int BYTE_LANES  = 8;
    localparam int SYNC_STAGES = 3;
    localparam logic [ADDR_W-1:0] RIGHT_MBOX_OFS = 18'h00000;
    localparam logic [ADDR_W-1:0] LEFT_MBOX_OFS  = 18'h00001;

    typedef enum logic [2:0] {
        DPMC_OP_HOLD    = 3'b000,
        DPMC_OP_CLEAR   = 3'b001,
        DPMC_OP_LOAD    = 3'b010,
        DPMC_OP_READ    = 3'b011,
        DPMC_OP_INCR    = 3'b100,
        DPMC_OP_MCLEAR  = 3'b101,
        DPMC_OP_MLOAD   = 3'b110,
        DPMC_OP_MREAD   = 3'b111
    } dpmc_op_t;
endpackage

// ==== core/dpmc_port_ctr.sv ====
/*
 * One port's burst counter, mirror and mask registers with readback and wrap flag.
 * Assumes control inputs are already on this clock and reset is synchronised.
 */
`timescale 1ns/1ps
module dpmc_port_ctr #(
    parameter int AW = dpmc_pkg::ADDR_W
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          cnt_sel,
    input  wire logic          clr_n,
    input  wire logic          load_n,
    input  wire logic          adv_n,
    input  wire logic          wrap_choice,
    input  wire logic [AW-1:0] addr_in,
    output logic      [AW-1:0] addr_out,
    output logic               addr_oe,
    output logic      [AW-1:0] counter,
    output logic               wrap_flag_n
);
    logic [AW-1:0] cnt_r, cnt_nxt, mir_r, mir_nxt, msk_r, msk_nxt, rd_r, rd_nxt;
    logic          oe_r, oe_nxt, flg_r, flg_nxt;
    logic [AW-1:0] inc_v, ones_v;
    dpmc_pkg::dpmc_op_t op;

    // --------------------------------------------------------------
    // Control decode
    // --------------------------------------------------------------
    always_comb begin
        if (cnt_sel) begin
            if (!clr_n)
                op = dpmc_pkg::DPMC_OP_CLEAR;
            else if (!load_n)
                op = adv_n ? dpmc_pkg::DPMC_OP_READ : dpmc_pkg::DPMC_OP_LOAD;
            else
                op = adv_n ? dpmc_pkg::DPMC_OP_HOLD : dpmc_pkg::DPMC_OP_INCR;
        end else begin
            if (!clr_n)
                op = dpmc_pkg::DPMC_OP_MCLEAR;
            else if (!load_n)
                op = adv_n ? dpmc_pkg::DPMC_OP_MREAD : dpmc_pkg::DPMC_OP_MLOAD;
            else
                op = dpmc_pkg::DPMC_OP_HOLD;
        end
    end

    // --------------------------------------------------------------
    // Register update
    // --------------------------------------------------------------
    always_comb begin
        // Only unmasked bits change; a masked bit 0 makes the step two.
        inc_v   = (cnt_r & ~msk_r) | (((cnt_r | ~msk_r) + {{(AW-1){1'b0}}, 1'b1}) & msk_r);
        ones_v  = cnt_r | ~msk_r;
        cnt_nxt = cnt_r;
        mir_nxt = mir_r;
        msk_nxt = msk_r;
        flg_nxt = flg_r;
        rd_nxt  = rd_r;
        oe_nxt  = 1'b0;
        case (op)
            // RL15 counter clear
            dpmc_pkg::DPMC_OP_CLEAR: begin
                cnt_nxt = cnt_r & ~msk_r;
                mir_nxt = mir_r & ~msk_r;
                flg_nxt = 1'b1;
            end
            // RL16 counter load
            dpmc_pkg::DPMC_OP_LOAD: begin
                cnt_nxt = addr_in;
                mir_nxt = addr_in;
                flg_nxt = 1'b1;
            end
            // RL17 counter readback
            dpmc_pkg::DPMC_OP_READ: begin
                rd_nxt = cnt_r;
                oe_nxt = 1'b1;
            end
            // RL18 counter increment
            dpmc_pkg::DPMC_OP_INCR: begin
                // RL2 wrap choice
                if (&ones_v)
                    cnt_nxt = wrap_choice ? mir_r : (cnt_r & ~msk_r);
                else
                    cnt_nxt = inc_v;
                // RL1 all ones flag
                flg_nxt = ~(&(cnt_nxt | ~msk_r));
            end
            // RL20 mask reset
            dpmc_pkg::DPMC_OP_MCLEAR: begin
                msk_nxt = '1;
                flg_nxt = 1'b1;
            end
            // RL21 mask load
            dpmc_pkg::DPMC_OP_MLOAD: begin
                msk_nxt = addr_in;
                flg_nxt = 1'b1;
            end
            // RL22 mask readback
            dpmc_pkg::DPMC_OP_MREAD: begin
                rd_nxt = msk_r;
                oe_nxt = 1'b1;
            end
            // RL19 RL24 hold all
            dpmc_pkg::DPMC_OP_HOLD: begin
                cnt_nxt = cnt_r;
            end
            default: begin
                cnt_nxt = cnt_r;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        // RL5 RL6 reset values
        if (rst) begin
            cnt_r <= '0;
            mir_r <= '0;
            msk_r <= '1;
            flg_r <= 1'b1;
            rd_r  <= '0;
            oe_r  <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            mir_r <= mir_nxt;
            msk_r <= msk_nxt;
            flg_r <= flg_nxt;
            rd_r  <= rd_nxt;
            oe_r  <= oe_nxt;
        end
    end

    assign addr_out    = rd_r;
    assign addr_oe     = oe_r;
    assign counter     = cnt_r;
    assign wrap_flag_n = flg_r;
endmodule

// ==== dv/dpmc_host.sv ====
/* Right-port host model: select, lanes, address, counter controls, global reset.
   Assumes the bench holds req for one cycle per single access. */
`timescale 1ns/1ps
module dpmc_host (
    input  wire logic        clk,
    input  wire logic        greq,
    input  wire logic        req,
    input  wire logic        rd,
    input  wire logic [7:0]  ln,
    input  wire logic [17:0] a,
    input  wire logic [3:0]  code,
    output logic             grst_n = 1'b0,
    output logic             sel_n,
    output logic             sel_hi,
    output logic             rnw,
    output logic [7:0]       ble_n,
    output logic [17:0]      addr,
    output logic [3:0]       ctl
);
    int n = 0;
    always @(posedge clk) begin
        n <= n + 1;
        grst_n <= #1 !(n < 6 || greq);
    end
    assign sel_n  = !req;
    assign sel_hi = req;
    assign rnw    = rd;
    assign ble_n  = ~ln;
    assign addr   = a;
    assign ctl    = code;
endmodule

// ==== dv/dpmc_chk.sv ====
/* Port checker for dpmc_top.
   Assumes CE and the global reset pin are driven from time zero. */
`timescale 1ns/1ps
module dpmc_chk (
    input wire logic        REF_CLK,
    input wire logic        SRST,
    input wire logic        CE,
    input wire logic        GLOBAL_RESET_INPUT_N,
    input wire logic [1:0]  LOW_ACTIVE_SELECT_N,
    input wire logic [1:0]  HIGH_ACTIVE_SELECT,
    input wire logic [1:0]  READ_NOT_WRITE,
    input wire logic [15:0] BYTE_LANE_ENABLE_N,
    input wire logic [35:0] ADDR_IN,
    input wire logic [1:0]  COUNTER_OR_MASK_SELECT,
    input wire logic [1:0]  COUNTER_CLEAR_INPUT_N,
    input wire logic [1:0]  LOAD_STROBE_N,
    input wire logic [1:0]  COUNT_ADVANCE_ENABLE_N,
    input wire logic [1:0]  FLOW_THROUGH_SELECT,
    input wire logic [35:0] ADDR_OUT,
    input wire logic [1:0]  ADDR_OE,
    input wire logic [35:0] COUNTER_ADDR,
    input wire logic [1:0]  COUNTER_WRAP_FLAG_N,
    input wire logic [1:0]  FLOW_THROUGH_MODE,
    input wire logic        RIGHT_MAILBOX_FLAG_N
);
    logic [2:0] gq_r;
    logic [2:0] gq_nxt;
    // Cycles since both resets went away, saturating at five; SRST restarts the synchroniser.
    always_comb gq_nxt = (!GLOBAL_RESET_INPUT_N || SRST) ? 3'h0
                         : (gq_r == 3'h5 ? gq_r : gq_r + 3'h1);
    always_ff @(posedge REF_CLK) gq_r <= gq_nxt;
    wire logic       ok = gq_r == 3'h5 && CE && !SRST;
    wire logic [3:0] c0 = {COUNTER_OR_MASK_SELECT[0], COUNTER_CLEAR_INPUT_N[0],
                           LOAD_STROBE_N[0], COUNT_ADVANCE_ENABLE_N[0]};
    wire logic [3:0] c1 = {COUNTER_OR_MASK_SELECT[1], COUNTER_CLEAR_INPUT_N[1],
                           LOAD_STROBE_N[1], COUNT_ADVANCE_ENABLE_N[1]};
    wire logic       lw = !LOW_ACTIVE_SELECT_N[0] && HIGH_ACTIVE_SELECT[0] && !READ_NOT_WRITE[0]
                          && ADDR_IN[17:0] == 18'h3ffff && BYTE_LANE_ENABLE_N[7:0] != 8'hff;
    wire logic       rr = !LOW_ACTIVE_SELECT_N[1] && HIGH_ACTIVE_SELECT[1] && READ_NOT_WRITE[1]
                          && ADDR_IN[35:18] == 18'h3ffff && BYTE_LANE_ENABLE_N[15:8] != 8'hff;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    fts_mode_a: assert property (FLOW_THROUGH_MODE == FLOW_THROUGH_SELECT)
        else $error("flow-through mode differs from select");
    srst_init_a: assert property (disable iff (1'b0) SRST && CE |=> COUNTER_ADDR == 36'h0
        && COUNTER_WRAP_FLAG_N == 2'h3 && RIGHT_MAILBOX_FLAG_N && ADDR_OE == 2'h0)
        else $error("sync reset state wrong");
    grst_init_a: assert property ((!GLOBAL_RESET_INPUT_N && CE) [*6] |->
        COUNTER_ADDR == 36'h0 && COUNTER_WRAP_FLAG_N == 2'h3 && RIGHT_MAILBOX_FLAG_N)
        else $error("global reset state wrong");
    load_cnt_a: assert property (ok && c0 == 4'hc |=> COUNTER_ADDR[17:0] == $past(ADDR_IN[17:0]))
        else $error("counter load wrong");
    hold_cnt_a: assert property (ok && (c0 == 4'hf || c0[2:0] == 3'h5 || c0[3:1] == 3'h3)
        |=> $stable(COUNTER_ADDR[17:0]) && $stable(COUNTER_WRAP_FLAG_N[0]))
        else $error("counter moved on hold");
    crbk_val_a: assert property (ok && c0 == 4'hd |=> ADDR_OE[0]
        && ADDR_OUT[17:0] == COUNTER_ADDR[17:0]) else $error("counter readback wrong");
    mrbk_val_a: assert property (ok && c0[3:2] == 2'h0 ##1 c0 == 4'h5
        |=> ADDR_OE[0] && ADDR_OUT[17:0] == 18'h3ffff) else $error("mask readback wrong");
    oe_idle_a: assert property (ok && c0[2:0] != 3'h5 |=> !ADDR_OE[0])
        else $error("address drive without readback");
    cnt_clr_a: assert property (ok && c0[3:2] == 2'h0 ##1 c0[3:2] == 2'h2
        |=> COUNTER_ADDR[17:0] == 18'h0) else $error("counter reset wrong");
    flag_clr_a: assert property (ok && (!c1[2] || c1[1:0] == 2'h0) |=> COUNTER_WRAP_FLAG_N[1])
        else $error("counter flag not cleared");
    mbox_set_a: assert property (ok && lw |=> !RIGHT_MAILBOX_FLAG_N)
        else $error("mailbox flag not set");
    mbox_idle_a: assert property (ok && RIGHT_MAILBOX_FLAG_N && !lw |=> RIGHT_MAILBOX_FLAG_N)
        else $error("mailbox flag set without cause");
    mbox_pend_a: assert property (ok && !RIGHT_MAILBOX_FLAG_N && !rr |=> !RIGHT_MAILBOX_FLAG_N)
        else $error("mailbox flag cleared without owner read");
    mbox_clr_a: assert property (ok && rr && !lw |=> RIGHT_MAILBOX_FLAG_N)
        else $error("mailbox flag not cleared");
    cover property (!COUNTER_WRAP_FLAG_N[0]);
    cover property ($fell(RIGHT_MAILBOX_FLAG_N));
    cover property (ADDR_OE[1]);
endmodule
bind dpmc_top dpmc_chk CHK (.*);

// ==== dv/tb.sv ====
/* Self-checking bench for dpmc_top with random and directed counter and mailbox traffic.
   Assumes dpmc_host drives the right port and the global reset pin. */
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        greq = 1'b0;
    logic [3:0]  c[2] = '{4'hf, 4'hf};
    logic [17:0] a[2] = '{18'h0, 18'h0};
    logic [7:0]  ln[2] = '{8'h0, 8'h0};
    logic [1:0]  cs = 2'h0, rd = 2'h0, wp = 2'h0, ft = 2'h0, mf, me, aoe, cf, fm, hid;
    logic [1:0]  dq, q1, q2;
    logic [17:0] mc[2], mm[2], mr[2], mo[2];
    logic [35:0] ao, ca;
    logic [31:0] sd = 32'h14c23;
    logic        rf, lf, rfo, lfo, hgn, hsn, hsh, hrw;
    logic [7:0]  hbl;
    logic [17:0] ha;
    logic [3:0]  hct;
    int          err_total = 0, num_checks = 0, cyc_n = 0;
    dpmc_host HOST (.clk(clk), .greq(greq), .req(cs[1]), .rd(rd[1]), .ln(ln[1]), .a(a[1]),
        .code(c[1]), .grst_n(hgn), .sel_n(hsn), .sel_hi(hsh), .rnw(hrw), .ble_n(hbl),
        .addr(ha), .ctl(hct));
    dpmc_top DUT (.REF_CLK(clk), .SRST(srst), .CE(1'b1), .GLOBAL_RESET_INPUT_N(hgn),
        .LOW_ACTIVE_SELECT_N({hsn, !cs[0]}), .HIGH_ACTIVE_SELECT({hsh, cs[0]}),
        .READ_NOT_WRITE({hrw, rd[0]}), .BYTE_LANE_ENABLE_N({hbl, ~ln[0]}), .ADDR_IN({ha, a[0]}),
        .COUNTER_OR_MASK_SELECT({hct[3], c[0][3]}), .COUNTER_CLEAR_INPUT_N({hct[2], c[0][2]}),
        .LOAD_STROBE_N({hct[1], c[0][1]}), .COUNT_ADVANCE_ENABLE_N({hct[0], c[0][0]}),
        .WRAP_CHOICE_INPUT(wp), .BLOCK_REPLAY_INPUT(2'h0), .FLOW_THROUGH_SELECT(ft),
        .ADDR_OUT(ao), .ADDR_OE(aoe), .COUNTER_ADDR(ca), .COUNTER_WRAP_FLAG_N(cf),
        .FLOW_THROUGH_MODE(fm), .DATA_OE(dq), .LEFT_MAILBOX_FLAG_N(lfo),
        .RIGHT_MAILBOX_FLAG_N(rfo));
    initial forever #2.5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Wrap to mirror or clear the unmasked bits.
    function automatic logic [17:0] incv(input logic [17:0] v, m, r, input logic w);
        if ((v & m) == m)
            return w ? r : (v & ~m);
        return (v & ~m) | ((v + (m[0] ? 18'h1 : 18'h2)) & m);
    endfunction
    task automatic chk(input logic [17:0] g, input logic [17:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic clr_model;
        mc = '{18'h0, 18'h0};
        mr = '{18'h0, 18'h0};
        mm = '{18'h3ffff, 18'h3ffff};
        mf = 2'h3;
        me = 2'h0;
        rf = 1'b1;
        lf = 1'b1;
        q1 = 2'h0;
        q2 = 2'h0;
    endtask
    task automatic cyc;
        @(posedge clk);
        for (int p = 0; p < 2; p++) begin
            mo[p] = c[p][3] ? mc[p] : mm[p];
            me[p] = c[p][2:0] == 3'h5;
            mr[p] = c[p] == 4'hc ? a[p] : (c[p][3:2] == 2'h2 ? mr[p] & ~mm[p] : mr[p]);
            casez (c[p])
                4'b10??: mc[p] = mc[p] & ~mm[p];
                4'b1100: mc[p] = a[p];
                4'b1110: mc[p] = incv(mc[p], mm[p], mr[p], wp[p]);
                4'b00??: mm[p] = 18'h3ffff;
                4'b0100: mm[p] = a[p];
                default: ;
            endcase
            if (c[p] == 4'he)
                mf[p] = (mc[p] & mm[p]) != mm[p];
            else if (!c[p][2] || c[p][1:0] == 2'h0)
                mf[p] = 1'b1;
            hid[p] = cs[p] && ln[p] != 8'h0 && a[p][17:1] == 17'h1ffff;
        end
        rf = (hid[0] && !rd[0] && a[0][0]) ? 1'b0 : ((hid[1] && rd[1] && a[1][0]) ? 1'b1 : rf);
        lf = (hid[1] && !rd[1] && !a[1][0]) ? 1'b0 : ((hid[0] && rd[0] && !a[0][0]) ? 1'b1 : lf);
        q2 = q1;
        q1 = cs & rd;
        #1;
        for (int p = 0; p < 2; p++) begin
            chk(ca[18*p +: 18], mc[p]);
            chk(cf[p], mf[p]);
            chk(aoe[p], me[p]);
            if (me[p])
                chk(ao[18*p +: 18], mo[p]);
            chk(dq[p], !me[p] && (ft[p] ? q1[p] : q2[p]));
        end
        chk(rfo, rf);
        chk(lfo, lf);
        chk(fm, ft);
    endtask
    task automatic rnd;
        for (int p = 0; p < 2; p++) begin
            sd = xs(sd);
            c[p] = sd[3:2] == 2'h0 ? sd[7:4] : 4'he;
            cs[p] = sd[8] & sd[9];
            rd[p] = sd[10];
            ln[p] = sd[12:11] == 2'h0 ? 8'h0 : sd[20:13];
            a[p] = sd[21] ? {17'h1ffff, sd[22]} : sd[31:14];
            wp[p] = sd[28];
            ft[p] = sd[29];
            if (c[p] == 4'h4)
                a[p] = 18'h3ffff >> (sd[26:22] % 18);
            if (c[p] == 4'h4 && sd[27] && a[p] > 18'h1)
                a[p] = a[p] - 18'h1;
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n > 5000) begin
            err_total++;
            test_done;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 srst = 1'b0;
        repeat (12) @(posedge clk);
        #1 clr_model;
        // Mask 3f, start 8, then increment through two wraps on each port.
        foreach (c[p]) {c[p], a[p], wp[p]} = {4'h4, 18'h3f, p[0]};
        cyc;
        foreach (c[p]) {c[p], a[p]} = {4'hc, 18'h8};
        cyc;
        c = '{4'he, 4'he};
        repeat (120) cyc;
        repeat (2000) begin
            rnd;
            cyc;
        end
        {c[0], c[1], cs, rd, ln[0], a[0]} = {8'hff, 2'h1, 2'h0, 8'hff, 18'h3ffff};
        cyc;
        cs = 2'h0;
        greq = 1'b1;
        repeat (8) @(posedge clk);
        #1 greq = 1'b0;
        repeat (8) @(posedge clk);
        #1 clr_model;
        foreach (c[p]) c[p] = 4'h0;
        cyc;
        foreach (c[p]) c[p] = 4'h5;
        cyc;
        foreach (c[p]) c[p] = 4'h8;
        cyc;
        foreach (c[p]) c[p] = 4'hd;
        cyc;
        srst = 1'b1;
        @(posedge clk);
        #1 srst = 1'b0;
        // SRST also restarts the global reset synchroniser, which holds reset four more edges.
        repeat (4) @(posedge clk);
        #1 clr_model;
        cyc;
        test_done;
    end
endmodule
